// >>> sim/srp_rx_port_chk.sv
// Purpose : Concurrent checks on the receive-side packet port
// Assumes : Sees only the top module's ports; one clock domain
// Notes   : Burst length is counted in helper logic, not unrolled
`timescale 1ns/1ps
`default_nettype none
module srp_rx_port_chk #(
    parameter MAXBURST1 = 8'h40
) (
    input wire logic        I_SYS_CLK,
    input wire logic        I_NRST,
    input wire logic        i_TX_VALID,
    input wire logic [15:0] i_TX_DATA,
    input wire logic        i_TX_CTL,
    input wire logic [3:0]  i_TX_PORT,
    input wire logic        o_TX_READY,
    input wire logic [15:0] o_RDAT,
    input wire logic        o_RCTL,
    input wire logic        o_RDCLK,
    input wire logic        I_RSCLK,
    input wire logic [1:0]  I_RSTAT,
    input wire logic        o_STAT_SYNC,
    input wire logic        o_DIP_ERR
);
    // ==========================================================
    // Takes within one ready window; cleared whenever ready is low
    logic [8:0] burst_cnt_q;
    logic [8:0] burst_cnt_d;
    assign burst_cnt_d = o_TX_READY ? burst_cnt_q + {8'h00, i_TX_VALID} : 9'h000;
    always_ff @(posedge I_SYS_CLK) begin
        burst_cnt_q <= I_NRST ? burst_cnt_d : 9'h000;
    end

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);

    sequence s_take;
        i_TX_VALID && o_TX_READY;
    endsequence
    sequence s_word_out;
        ##1 (o_RDAT == $past(i_TX_DATA)) && (o_RCTL == $past(i_TX_CTL));
    endsequence

    property p_word_out;    s_take |-> s_word_out; endproperty
    property p_idle_word;   !(i_TX_VALID && o_TX_READY) |=> (o_RDAT == 16'h000F) && o_RCTL; endproperty
    property p_clk_toggle;  1'b1 |=> o_RDCLK != $past(o_RDCLK); endproperty
    property p_burst_limit; burst_cnt_q <= MAXBURST1; endproperty
    property p_drop_take;   $fell(o_TX_READY) |-> $past(i_TX_VALID); endproperty
    property p_dip_pulse;   o_DIP_ERR |-> !o_STAT_SYNC ##1 !o_DIP_ERR; endproperty

    a_word_out:    assert property (p_word_out)    else $error("link word differs from taken word");
    a_idle_word:   assert property (p_idle_word)   else $error("idle word or flag wrong");
    a_clk_toggle:  assert property (p_clk_toggle)  else $error("data clock did not toggle");
    a_burst_limit: assert property (p_burst_limit) else $error("burst longer than allowance");
    a_drop_take:   assert property (p_drop_take)   else $error("ready dropped without a take");
    a_dip_pulse:   assert property (p_dip_pulse)   else $error("check error pulse malformed");
endmodule
bind srp_rx_port srp_rx_port_chk #(.MAXBURST1(MAXBURST1)) u_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .i_TX_VALID(i_TX_VALID), .i_TX_DATA(i_TX_DATA),
    .i_TX_CTL(i_TX_CTL), .i_TX_PORT(i_TX_PORT), .o_TX_READY(o_TX_READY), .o_RDAT(o_RDAT),
    .o_RCTL(o_RCTL), .o_RDCLK(o_RDCLK), .I_RSCLK(I_RSCLK), .I_RSTAT(I_RSTAT),
    .o_STAT_SYNC(o_STAT_SYNC), .o_DIP_ERR(o_DIP_ERR)
);
`default_nettype wire

// >>> sim/srp_stat_src.sv
// Purpose : Far-side status source sending framed round-robin port status
// Assumes : 400 ns status clock, running only inside frames
// Notes   : Lines show the inverse of the check code once a frame ends
`timescale 1ns/1ps
`default_nettype none
module srp_stat_src (
    output var logic       o_rsclk,
    output var logic [1:0] o_rstat
);
    initial begin
        o_rsclk = 1'b0;
        o_rstat = 2'h0;
    end
    // ==========================================================
    // One entry per status clock; set up 100 ns before the rise
    task automatic send_word(input logic [1:0] v);
        o_rstat = v;
        #100 o_rsclk = 1'b1;
        #200 o_rsclk = 1'b0;
        #100;
    endtask
    task automatic send_frame(input logic [19:0] ent, input logic bad);
        logic [1:0] chk;
        integer     p;
        chk = 2'h0;
        send_word(2'h3);
        for (p = 0; p < 10; p++) begin
            send_word(ent[2*p +: 2]);
            chk = chk ^ ent[2*p +: 2];
        end
        chk = ~chk ^ {1'b0, bad};
        send_word(chk);
        o_rstat = ~chk;
    endtask
endmodule
`default_nettype wire

// >>> sim/test_srp_rx_port.sv
// Purpose : Self-checking bench for the receive-side packet port
// Assumes : Partner status source drives the status link
// Notes   : Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module test_srp_rx_port;
    logic        clk;
    logic        nrst;
    logic        tx_valid;
    logic [15:0] tx_data;
    logic        tx_ctl;
    logic [3:0]  tx_port;
    wire         tx_ready, rdclk, rctl, stat_sync, dip_err, rsclk;
    wire  [15:0] rdat;
    wire  [1:0]  rstat;
    integer      fail_count = 0;
    integer      samples_checked = 0;
    // Port 3 starving, ports 5 and 7 hungry, the rest satisfied
    localparam logic [19:0] FRAME = 20'hA662A;

    srp_rx_port dut (
        .I_SYS_CLK(clk), .I_NRST(nrst), .i_TX_VALID(tx_valid), .i_TX_DATA(tx_data), .i_TX_CTL(tx_ctl),
        .i_TX_PORT(tx_port), .o_TX_READY(tx_ready), .o_RDAT(rdat), .o_RCTL(rctl), .o_RDCLK(rdclk),
        .I_RSCLK(rsclk), .I_RSTAT(rstat), .o_STAT_SYNC(stat_sync), .o_DIP_ERR(dip_err)
    );
    srp_stat_src u_stat (.o_rsclk(rsclk), .o_rstat(rstat));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic hold_refused(input logic [3:0] port);
        tx_valid = 1'b1;
        tx_ctl = 1'b0;
        tx_port = port;
        repeat (10) begin
            step(1);
            check(tx_ready, 1'b0);
        end
    endtask
    // Offers words until the burst closes; ctl_at marks a control word
    task automatic run_burst(input logic [3:0] port, input integer ctl_at, input integer exp);
        integer n, t;
        logic   rdy;
        n = 0;
        tx_valid = 1'b1;
        tx_ctl = (ctl_at == 0);
        tx_port = port;
        tx_data = 16'hA000;
        for (t = 0; t < 3000; t++) begin
            rdy = tx_ready;
            step(1);
            if (rdy === 1'b1) begin
                check(rdat, 16'hA000 + n[15:0]);
                check(rctl, n == ctl_at);
                n++;
                tx_data = 16'hA000 + n[15:0];
                tx_ctl = (n == ctl_at);
                if (tx_ready !== 1'b1) break;
            end
        end
        tx_valid = 1'b0;
        check(n[15:0], exp[15:0]);
    endtask
    task test_done;
        $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        logic prev;
        step(20);
        check(rdat, 16'h000F);
        check({rctl, tx_ready, stat_sync, dip_err}, 4'h8);
        nrst = 1'b1;
        step(1);
        repeat (4) begin
            prev = rdclk;
            step(1);
            check(rdclk != prev, 1'b1);
        end
        $display("test reset done");
    endtask
    task t_ctl_word;
        run_burst(4'h0, 0, 1);
        step(1);
        check(rdat, 16'h000F);
        check(rctl, 1'b1);
        $display("test control word done");
    endtask
    task t_bursts;
        hold_refused(4'h3);
        fork
            u_stat.send_frame(FRAME, 1'b0);
            run_burst(4'h3, -1, 64);
        join
        step(8);
        check(stat_sync, 1'b1);
        run_burst(4'h5, -1, 32);
        step(3);
        run_burst(4'h7, 5, 6);
        step(3);
        // Valid stays up: the refused request waits for the next good frame
        hold_refused(4'h3);
        $display("test bursts done");
    endtask
    // Stray framing inside a frame restarts the count and drops sync until the check code
    task t_restart;
        integer lows;
        lows = 0;
        fork
            begin
                u_stat.send_word(2'h3);
                u_stat.send_word(2'h1);
                u_stat.send_frame(FRAME, 1'b0);
            end
            run_burst(4'h3, -1, 64);
            repeat (130) begin
                step(1);
                lows += !stat_sync;
            end
        join
        check(lows[15:0], 16'h0058);
        check(stat_sync, 1'b1);
        $display("test restart done");
    endtask
    task t_bad_frame;
        integer hits;
        hits = 0;
        fork
            u_stat.send_frame(20'hAAAAA, 1'b1);
            repeat (120) begin
                step(1);
                hits += dip_err;
            end
        join
        check(hits[15:0], 16'h0001);
        check(stat_sync, 1'b0);
        $display("test bad frame done");
    endtask

    initial begin
        nrst = 1'b0;
        tx_valid = 1'b0;
        tx_data = 16'h0000;
        tx_ctl = 1'b0;
        tx_port = 4'h0;
        t_reset;
        t_ctl_word;
        t_bursts;
        t_restart;
        t_bad_frame;
        test_done;
    end
    initial begin
        #(4000 * 50);
        fail_count++;
        test_done;
    end
endmodule
`default_nettype wire

// >>> src/srp_defs.vh
// Purpose : Shared constants for the receive-side packet port
// Assumes : Included by bare name from the design files
// Notes   : Definitions only
`ifndef SRP_DEFS_VH
`define SRP_DEFS_VH

// ==========================================================
// Data clock figures
`define SRP_REF_CLK_MHZ      50
`define SRP_RDCLK_MULT       8
`define SRP_RDCLK_MIN_MHZ    336
`define SRP_RDCLK_MAX_MHZ    400

// ==========================================================
// Link words and status codes
`define SRP_IDLE_WORD        16'h000F
`define SRP_ST_STARVING      2'h0
`define SRP_ST_HUNGRY        2'h1
`define SRP_ST_SATISFIED     2'h2
`define SRP_ST_FRAMING       2'h3

// ==========================================================
// Port table and burst allowances, in 16-bit words
`define SRP_NPORTS           10
`define SRP_PORT_W           4
`define SRP_CNT_W            8
`define SRP_MAXBURST1        8'h40
`define SRP_MAXBURST2        8'h20

`endif

// >>> src/srp_rx_port.v
// Purpose : Receive-direction packet port: launches payload and control words on the
//           16-bit double-rate bus and obeys per-port FIFO status from the partner
// Assumes : I_RSCLK/I_RSTAT come from another domain; user side is on I_SYS_CLK
// Notes   : One word per system cycle; the data clock toggles every cycle so each
//           clock edge carries a word. The 8x multiplier is a parameter for the PLL.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.vh"

module srp_rx_port #(
    parameter NPORTS    = `SRP_NPORTS,
    parameter PORT_W    = `SRP_PORT_W,
    parameter MAXBURST1 = `SRP_MAXBURST1,
    parameter MAXBURST2 = `SRP_MAXBURST2,
    parameter REF_MHZ   = `SRP_REF_CLK_MHZ,
    parameter MULT      = `SRP_RDCLK_MULT
) (
    input  wire              I_SYS_CLK,
    input  wire              I_NRST,
    input  wire              i_TX_VALID,
    input  wire [15:0]       i_TX_DATA,
    input  wire              i_TX_CTL,
    input  wire [PORT_W-1:0] i_TX_PORT,
    output reg               o_TX_READY,
    output reg  [15:0]       o_RDAT,
    output reg               o_RCTL,
    output reg               o_RDCLK,
    input  wire              I_RSCLK,
    input  wire [1:0]        I_RSTAT,
    output reg               o_STAT_SYNC,
    output reg               o_DIP_ERR
);

    // ==========================================================
    // Data clock rate figure, kept for the PLL and for checking the range
    localparam RDCLK_MHZ = REF_MHZ * MULT;
    localparam RDCLK_OK  = (RDCLK_MHZ >= `SRP_RDCLK_MIN_MHZ) && (RDCLK_MHZ <= `SRP_RDCLK_MAX_MHZ);

    localparam integer      LAST_IDX  = NPORTS - 1;
    localparam [PORT_W-1:0] LAST_PORT = LAST_IDX[PORT_W-1:0];

    // Sender states
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_PASS = 3'h1;
    localparam [2:0] S_LOOK = 3'h2;
    localparam [2:0] S_SEND = 3'h3;
    localparam [2:0] S_MARK = 3'h4;
    localparam [2:0] S_WAIT = 3'h5;

    // Status decoder states
    localparam [1:0] F_HUNT = 2'h0;
    localparam [1:0] F_ENT  = 2'h1;
    localparam [1:0] F_DIP  = 2'h2;

    function [`SRP_CNT_W-1:0] allow_of;
        input [1:0] st;
        begin
            case (st)
                `SRP_ST_STARVING: allow_of = MAXBURST1;
                `SRP_ST_HUNGRY:   allow_of = MAXBURST2;
                default:          allow_of = {`SRP_CNT_W{1'b0}};
            endcase
        end
    endfunction

    // ==========================================================
    // Status input synchronisers
    reg              rsclk_s1_q;
    reg              rsclk_s2_q;
    reg              rsclk_s3_q;
    reg  [1:0]       rstat_s1_q;
    reg  [1:0]       rstat_s2_q;
    wire             rsclk_rise = rsclk_s2_q & ~rsclk_s3_q;

    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            rsclk_s1_q <= 1'b0;
            rsclk_s2_q <= 1'b0;
            rsclk_s3_q <= 1'b0;
            rstat_s1_q <= 2'h0;
            rstat_s2_q <= 2'h0;
        end else begin
            rsclk_s1_q <= I_RSCLK;
            rsclk_s2_q <= rsclk_s1_q;
            rsclk_s3_q <= rsclk_s2_q;
            rstat_s1_q <= I_RSTAT;
            rstat_s2_q <= rstat_s1_q;
        end
    end

    // ==========================================================
    // Status frame decoder: framing, one entry per port, then check code
    reg  [1:0]        fst_q;
    reg  [PORT_W-1:0] fidx_q;
    reg  [1:0]        dip_q;
    reg               commit_q;
    reg               frame_we;

    always @* begin
        frame_we = rsclk_rise && (fst_q == F_ENT) && (rstat_s2_q != `SRP_ST_FRAMING);
    end

    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            fst_q       <= F_HUNT;
            fidx_q      <= {PORT_W{1'b0}};
            dip_q       <= 2'h0;
            commit_q    <= 1'b0;
            o_STAT_SYNC <= 1'b0;
            o_DIP_ERR   <= 1'b0;
        end else begin
            commit_q  <= 1'b0;
            o_DIP_ERR <= 1'b0;
            if (rsclk_rise) begin
                case (fst_q)
                    F_HUNT: begin
                        if (rstat_s2_q == `SRP_ST_FRAMING) begin
                            fst_q  <= F_ENT;
                            fidx_q <= {PORT_W{1'b0}};
                            dip_q  <= 2'h0;
                        end
                    end
                    F_ENT: begin
                        if (rstat_s2_q == `SRP_ST_FRAMING) begin
                            // Framing inside a frame: restart counting from here
                            fidx_q <= {PORT_W{1'b0}};
                            dip_q  <= 2'h0;
                            o_STAT_SYNC <= 1'b0;
                        end else begin
                            dip_q <= dip_q ^ rstat_s2_q;
                            if (fidx_q == LAST_PORT) begin
                                fst_q <= F_DIP;
                            end else begin
                                fidx_q <= fidx_q + 1'b1;
                            end
                        end
                    end
                    default: begin
                        // Check code is the inverted XOR of all entries
                        if (rstat_s2_q == ~dip_q) begin
                            commit_q    <= 1'b1;
                            o_STAT_SYNC <= 1'b1;
                        end else begin
                            o_DIP_ERR   <= 1'b1;
                            o_STAT_SYNC <= 1'b0;
                        end
                        fst_q <= F_HUNT;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Port status table
    reg  [2:0]        st_q;
    reg  [PORT_W-1:0] port_q;
    wire [1:0]        st_rdata;
    wire              mark_we = (st_q == S_MARK) && !frame_we;

    srp_status_mem #(
        .DEPTH  (NPORTS),
        .ADDR_W (PORT_W)
    ) u_mem (
        .i_clk   (I_SYS_CLK),
        .i_nrst  (I_NRST),
        .i_we    (frame_we | mark_we),
        .i_waddr (frame_we ? fidx_q : port_q),
        .i_wdata (frame_we ? rstat_s2_q : `SRP_ST_SATISFIED),
        .i_raddr ((st_q == S_IDLE) ? i_TX_PORT : port_q),
        .o_rdata (st_rdata)
    );

    // ==========================================================
    // Sender: bursts limited by the port's reported space
    reg  [`SRP_CNT_W-1:0] cnt_q;
    wire                  take = i_TX_VALID & o_TX_READY;
    wire [`SRP_CNT_W-1:0] allow = allow_of(st_rdata);

    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            st_q       <= S_IDLE;
            port_q     <= {PORT_W{1'b0}};
            cnt_q      <= {`SRP_CNT_W{1'b0}};
            o_TX_READY <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (i_TX_VALID && i_TX_CTL) begin
                        o_TX_READY <= 1'b1;
                        st_q       <= S_PASS;
                    end else if (i_TX_VALID) begin
                        port_q <= i_TX_PORT;
                        st_q   <= S_LOOK;
                    end
                end
                S_PASS: begin
                    if (take) begin
                        o_TX_READY <= 1'b0;
                        st_q       <= S_IDLE;
                    end
                end
                S_LOOK: begin
                    if (allow == {`SRP_CNT_W{1'b0}}) begin
                        st_q <= S_WAIT;
                    end else begin
                        cnt_q      <= allow;
                        o_TX_READY <= 1'b1;
                        st_q       <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (take) begin
                        if (i_TX_CTL || (cnt_q == 8'h01)) begin
                            o_TX_READY <= 1'b0;
                            st_q       <= S_MARK;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                end
                S_MARK: begin
                    // Burst closed (allowance used up or control word): port is held off until the next frame rewrites it
                    if (mark_we) begin
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    if (commit_q) begin
                        st_q <= S_LOOK;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Link output: one word per system cycle, clock toggles each cycle
    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            o_RDAT  <= `SRP_IDLE_WORD;
            o_RCTL  <= 1'b1;
            o_RDCLK <= 1'b0;
        end else begin
            o_RDCLK <= ~o_RDCLK;
            if (take) begin
                o_RDAT <= i_TX_DATA;
                o_RCTL <= i_TX_CTL;
            end else begin
                o_RDAT <= `SRP_IDLE_WORD;
                o_RCTL <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> src/srp_status_mem.v
// Purpose : Per-port table of the latest decoded FIFO status
// Assumes : One write port, one read port, same clock
// Notes   : Read data is registered; a read in a write cycle returns the old entry
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.vh"

module srp_status_mem #(
    parameter DEPTH  = 10,
    parameter ADDR_W = 4
) (
    input  wire              i_clk,
    input  wire              i_nrst,
    input  wire              i_we,
    input  wire [ADDR_W-1:0] i_waddr,
    input  wire [1:0]        i_wdata,
    input  wire [ADDR_W-1:0] i_raddr,
    output reg  [1:0]        o_rdata
);

    reg [1:0] mem_q [0:DEPTH-1];

    // ==========================================================
    // Storage; every entry starts satisfied so no data burst is sent unasked
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
            always @(posedge i_clk) begin
                if (!i_nrst) begin
                    mem_q[g] <= `SRP_ST_SATISFIED;
                end else if (i_we && (i_waddr == g)) begin
                    mem_q[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Registered read; out-of-range addresses read as satisfied
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_rdata <= `SRP_ST_SATISFIED;
        end else if (i_raddr < DEPTH) begin
            o_rdata <= mem_q[i_raddr];
        end else begin
            o_rdata <= `SRP_ST_SATISFIED;
        end
    end

endmodule

`default_nettype wire
